/* pkg/pfc_pkg.sv */
package pfc_pkg;
  localparam int CLK_NS = 100;
  localparam int CNT_W = 24;
  typedef logic [CNT_W-1:0] pfc_cnt_t;
  // command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_IDENT = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_CFG_SETUP = 8'h60;
  localparam logic [7:0] CMD_BURST_CONF = 8'h03;
  localparam logic [7:0] CMD_PROTECT_CONF = 8'h01;
  localparam logic [7:0] CMD_OTP_SETUP = 8'hC0;
  localparam logic [7:0] CMD_WORD_PROG = 8'h40;
  localparam logic [7:0] CMD_WORD_PROG_ALT = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_BUF_PROG = 8'hE8;
  // word address map (address bit 0 is pin A1)
  localparam int ADDR_W = 21;
  localparam logic [20:0] ID_MFR_ADDR = 21'h000000;
  localparam logic [20:0] ID_DEV_ADDR = 21'h000001;
  localparam logic [20:0] ID_BCR_ADDR = 21'h000005;
  localparam logic [14:0] ID_PROT_OFS = 15'h0002;
  localparam logic [20:0] OTP_BASE = 21'h000080;
  localparam logic [20:0] OTP_LAST = 21'h000088;
  localparam int OTP_WORDS = 9;
  localparam logic [3:0] OTP_LOCK_IDX = 4'h0;
  localparam logic [3:0] OTP_USER_LO = 4'h5;
  localparam int LOCK_USER_BIT = 1;
  localparam int LOCK_FACT_BIT = 0;
  localparam logic [15:0] OTP_ERASED = 16'hFFFF;
  localparam logic [15:0] LOCK_RESET = 16'hFFFE;
  localparam int BLK_LSB = 15;
  localparam int BLK_MSB = 20;
  localparam int NUM_BLOCKS = 64;
  localparam int ROW_LSB = 4;
  localparam logic [15:0] BUF_MAX = 16'h000F;
  // status register bits
  localparam int SR_READY = 7;
  localparam int SR_ESUSP = 6;
  localparam int SR_EERR = 5;
  localparam int SR_PERR = 4;
  localparam int SR_VPP = 3;
  localparam int SR_PSUSP = 2;
  localparam int SR_PROT = 1;
  localparam logic [7:0] SR_ERR_MASK = 8'h3A;
  // operation times
  localparam int T_WORD_NS = 18000;
  localparam int T_BUF_NS = 290000;
  localparam int T_PROT_NS = 18000;
  localparam int T_ERASE_NS = 1100000000;
  localparam int T_UNPROT_NS = 750000000;
  localparam int T_PSUSP_NS = 20000;
  localparam int T_ESUSP_NS = 25000;
  localparam int WORD_CYC = T_WORD_NS / CLK_NS;
  localparam int BUF_CYC = T_BUF_NS / CLK_NS;
  localparam int PROT_CYC = T_PROT_NS / CLK_NS;
  localparam int PSUSP_CYC = T_PSUSP_NS / CLK_NS;
  localparam int ESUSP_CYC = T_ESUSP_NS / CLK_NS;
  typedef enum logic [2:0] {
    OP_WORD = 3'h0, OP_BUF = 3'h1, OP_ERASE = 3'h2,
    OP_PROT = 3'h3, OP_UNPROT = 3'h4, OP_OTP = 3'h5
  } pfc_op_e;
  typedef enum logic [1:0] {
    RM_ARRAY = 2'h0, RM_IDENT = 2'h1, RM_STATUS = 2'h2, RM_QUERY = 2'h3
  } pfc_rmode_e;
endpackage

/* src/pfc_pe_ctrl.sv */
`timescale 1ns/1ps
module pfc_pe_ctrl #(
  parameter int ERASE_CYC = pfc_pkg::T_ERASE_NS / pfc_pkg::CLK_NS,
  parameter int UNPROT_CYC = pfc_pkg::T_UNPROT_NS / pfc_pkg::CLK_NS
) (
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // control
  input wire logic i_start,
  input wire logic [2:0] i_kind,
  input wire logic i_suspend,
  input wire logic i_resume,
  // state
  output logic o_busy,
  output logic o_done,
  output logic o_susp_prog,
  output logic o_susp_erase
);
  typedef enum logic [1:0] {PE_IDLE = 2'h0, PE_RUN = 2'h1, PE_PAUSE = 2'h3} pfc_pe_e;
  pfc_pe_e state;
  logic [2:0] kind;
  pfc_pkg::pfc_cnt_t cnt;
  pfc_pkg::pfc_cnt_t lat;
  logic lat_on;

  function automatic pfc_pkg::pfc_cnt_t op_cycles(input logic [2:0] k);
    case (k)
      pfc_pkg::OP_BUF: op_cycles = pfc_pkg::pfc_cnt_t'(pfc_pkg::BUF_CYC);
      pfc_pkg::OP_ERASE: op_cycles = pfc_pkg::pfc_cnt_t'(ERASE_CYC);
      pfc_pkg::OP_PROT: op_cycles = pfc_pkg::pfc_cnt_t'(pfc_pkg::PROT_CYC);
      pfc_pkg::OP_UNPROT: op_cycles = pfc_pkg::pfc_cnt_t'(UNPROT_CYC);
      default: op_cycles = pfc_pkg::pfc_cnt_t'(pfc_pkg::WORD_CYC);
    endcase
  endfunction

  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
    begin
      state <= PE_IDLE;
      kind <= 3'h0;
      cnt <= '0;
      lat <= '0;
      lat_on <= 1'b0;
      o_done <= 1'b0;
    end
    else if (i_ce)
    begin
      o_done <= 1'b0;
      case (state)
        PE_IDLE:
          if (i_start)
          begin
            state <= PE_RUN;
            kind <= i_kind;
            cnt <= op_cycles(i_kind);
            lat_on <= 1'b0;
          end
        PE_RUN:
          if (cnt == pfc_pkg::pfc_cnt_t'(1))
          begin
            // finishing beats a pending pause
            state <= PE_IDLE;
            o_done <= 1'b1;
          end
          else
          begin
            cnt <= cnt - pfc_pkg::pfc_cnt_t'(1);
            if (lat_on && lat == pfc_pkg::pfc_cnt_t'(1))
            begin
              state <= PE_PAUSE;
              lat_on <= 1'b0;
            end
            else if (lat_on)
              lat <= lat - pfc_pkg::pfc_cnt_t'(1);
            else if (i_suspend)
            begin
              lat_on <= 1'b1;
              lat <= (kind == pfc_pkg::OP_ERASE) ? pfc_pkg::pfc_cnt_t'(pfc_pkg::ESUSP_CYC)
                                                   : pfc_pkg::pfc_cnt_t'(pfc_pkg::PSUSP_CYC);
            end
          end
        PE_PAUSE:
          if (i_resume)
            state <= PE_RUN;
        default:
          state <= PE_IDLE;
      endcase
    end

  assign o_busy = (state == PE_RUN);
  assign o_susp_erase = (state == PE_PAUSE) && (kind == pfc_pkg::OP_ERASE);
  assign o_susp_prog = (state == PE_PAUSE) && (kind != pfc_pkg::OP_ERASE);
endmodule // pfc_pe_ctrl

/* src/pfc_cmd_if.sv */
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
// Behaviour
// - burst config: 60h then 03h, value carried on the address lines
// - config bit n comes from address line n+1; other lines ignored
// - after burst config write, reads return array data
// - 60h then 01h protects the addressed block and starts the controller
// - after protect or unprotect, reads return status
// - protection bits survive bus reset; only unprotect-all or power-on clears them
// - 60h then D0h starts unprotect of every block
// - C0h then one 16-bit word programs the protection register
// - lock bit 1 low locks user words until power-on, bit 0 factory words permanently
// - programming a locked area changes nothing and flags a status error
// - no suspend during protection register programming
// - FFh array, 90h identifier, 70h status, 98h query read modes
// - 50h clears errors, B0h suspends, D0h resumes
// - word program 40h/10h plus address/data; erase 20h plus D0h
// - buffered program: E8h, count N, N+1 words, then D0h
// - identifier block base+02h gives protection; word 5 gives burst config
// - identifier words 0 and 1 give codes; protection register from 80h
// - protection window: 0 lock, 1-4 factory id, 5-8 user words
// - suspend pauses program within 20 us, erase within 25 us
// - status bit 7 low while controller busy, high when idle
// - clear-status zeroes bits 1,3,4,5; they hold otherwise until reset
module pfc_cmd_if #(
  parameter int ERASE_CYC = pfc_pkg::T_ERASE_NS / pfc_pkg::CLK_NS,
  parameter int UNPROT_CYC = pfc_pkg::T_UNPROT_NS / pfc_pkg::CLK_NS,
  parameter logic [15:0] MFR_CODE = 16'h1A2B, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h3C4D  // arbitrary value
) (
  // clock, resets, enable
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_por,
  input wire logic i_ce,
  // avalon-mm slave, word addressed
  input wire logic [20:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [15:0] i_avs_writedata,
  output logic [15:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // pins and array
  input wire logic i_vpp_ok,
  input wire logic [15:0] i_array_word,
  // operation hand-off
  output logic o_op_start,
  output logic [2:0] o_op_kind,
  output logic [20:0] o_op_address,
  output logic [15:0] o_op_word,
  output logic o_op_busy,
  output logic [15:0] o_burst_config
);
  typedef enum logic [2:0] {
    SQ_IDLE = 3'h0, SQ_CFG = 3'h1, SQ_OTP = 3'h3, SQ_PROG = 3'h2,
    SQ_ERASE = 3'h6, SQ_BCOUNT = 3'h7, SQ_BDATA = 3'h5, SQ_BCONF = 3'h4
  } pfc_seq_e;

  pfc_seq_e seq;
  pfc_seq_e next_seq;
  pfc_pkg::pfc_rmode_e rmode;
  pfc_pkg::pfc_rmode_e next_rmode;
  logic ack;
  logic req;
  logic take;
  logic wr;
  logic vpp_meta;
  logic vpp_ok;
  logic [7:0] err;
  logic [7:0] set_err;
  logic clr_err;
  logic [pfc_pkg::NUM_BLOCKS-1:0] prot;
  logic [15:0] otp [pfc_pkg::OTP_WORDS];
  logic [3:0] otp_idx;
  logic otp_we;
  logic bcr_we;
  logic start;
  logic [2:0] start_kind;
  logic [20:0] start_addr;
  logic [20:0] buf_base;
  logic [20:0] buf_row;
  logic buf_first;
  logic [3:0] buf_left;
  logic buf_load;
  logic susp_req;
  logic resume_req;
  logic pec_done;
  logic susp_prog;
  logic susp_erase;
  logic [7:0] status;
  logic [7:0] cmd;

  function automatic logic [5:0] blk_of(input logic [20:0] a);
    blk_of = a[pfc_pkg::BLK_MSB:pfc_pkg::BLK_LSB];
  endfunction

  // status error bits for an operation that cannot start; zero means go
  function automatic logic [7:0] fail_bits(input logic [2:0] k, input logic vpp, input logic locked);
    logic [7:0] f;
    f = 8'h00;
    if (!vpp)
      f[pfc_pkg::SR_VPP] = 1'b1;
    if (locked)
      f[pfc_pkg::SR_PROT] = 1'b1;
    if (f != 8'h00)
    begin
      if (k == pfc_pkg::OP_ERASE || k == pfc_pkg::OP_UNPROT)
        f[pfc_pkg::SR_EERR] = 1'b1;
      else
        f[pfc_pkg::SR_PERR] = 1'b1;
    end
    fail_bits = f;
  endfunction

  // one wait state per access; the bus is on our clock so no synchroniser
  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~(ack & i_ce);
  assign take = req & ack & i_ce;
  assign wr = take & i_avs_write;
  assign cmd = i_avs_writedata[7:0];
  assign otp_idx = 4'(i_avs_address - pfc_pkg::OTP_BASE);

  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
      ack <= 1'b0;
    else if (i_ce)
      ack <= req & ~ack;

  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
    begin
      vpp_meta <= 1'b0;
      vpp_ok <= 1'b0;
    end
    else if (i_ce)
    begin
      vpp_meta <= i_vpp_ok;
      vpp_ok <= vpp_meta;
    end

  // command decoder
  always_comb
  begin
    next_seq = seq;
    next_rmode = rmode;
    set_err = 8'h00;
    clr_err = 1'b0;
    otp_we = 1'b0;
    bcr_we = 1'b0;
    start = 1'b0;
    start_kind = pfc_pkg::OP_WORD;
    start_addr = i_avs_address;
    buf_load = 1'b0;
    susp_req = 1'b0;
    resume_req = 1'b0;
    if (wr && o_op_busy)
    begin
      // a running controller hears only status read and suspend
      if (cmd == pfc_pkg::CMD_READ_STATUS)
        next_rmode = pfc_pkg::RM_STATUS;
      else if (cmd == pfc_pkg::CMD_SUSPEND && o_op_kind != pfc_pkg::OP_OTP &&
               o_op_kind != pfc_pkg::OP_PROT && o_op_kind != pfc_pkg::OP_UNPROT)
      begin
        susp_req = 1'b1;
        next_rmode = pfc_pkg::RM_STATUS;
      end
    end
    else if (wr && (susp_prog || susp_erase))
    begin
      // nested program inside erase suspend is not offered
      case (cmd)
        pfc_pkg::CMD_READ_ARRAY: next_rmode = pfc_pkg::RM_ARRAY;
        pfc_pkg::CMD_READ_IDENT: next_rmode = pfc_pkg::RM_IDENT;
        pfc_pkg::CMD_READ_STATUS: next_rmode = pfc_pkg::RM_STATUS;
        pfc_pkg::CMD_READ_QUERY: next_rmode = pfc_pkg::RM_QUERY;
        pfc_pkg::CMD_CONFIRM:
        begin
          resume_req = 1'b1;
          next_rmode = pfc_pkg::RM_STATUS;
        end
        default: next_rmode = rmode;
      endcase
    end
    else if (wr)
    begin
      next_seq = pfc_seq_e'(SQ_IDLE);
      case (seq)
        SQ_IDLE:
          case (cmd)
            pfc_pkg::CMD_READ_ARRAY: next_rmode = pfc_pkg::RM_ARRAY;
            pfc_pkg::CMD_READ_IDENT: next_rmode = pfc_pkg::RM_IDENT;
            pfc_pkg::CMD_READ_STATUS: next_rmode = pfc_pkg::RM_STATUS;
            pfc_pkg::CMD_READ_QUERY: next_rmode = pfc_pkg::RM_QUERY;
            pfc_pkg::CMD_CLEAR_STATUS: clr_err = 1'b1;
            pfc_pkg::CMD_CFG_SETUP: next_seq = SQ_CFG;
            pfc_pkg::CMD_OTP_SETUP: next_seq = SQ_OTP;
            pfc_pkg::CMD_WORD_PROG, pfc_pkg::CMD_WORD_PROG_ALT: next_seq = SQ_PROG;
            pfc_pkg::CMD_ERASE_SETUP: next_seq = SQ_ERASE;
            pfc_pkg::CMD_BUF_PROG:
            begin
              next_seq = SQ_BCOUNT;
              buf_load = 1'b1;
              next_rmode = pfc_pkg::RM_STATUS;
            end
            default: next_seq = SQ_IDLE;
          endcase
        SQ_CFG:
        begin
          next_rmode = pfc_pkg::RM_STATUS;
          if (cmd == pfc_pkg::CMD_BURST_CONF)
          begin
            bcr_we = 1'b1;
            next_rmode = pfc_pkg::RM_ARRAY;
          end
          else if (cmd == pfc_pkg::CMD_PROTECT_CONF || cmd == pfc_pkg::CMD_CONFIRM)
          begin
            start_kind = (cmd == pfc_pkg::CMD_CONFIRM) ? pfc_pkg::OP_UNPROT : pfc_pkg::OP_PROT;
            set_err = fail_bits(start_kind, vpp_ok, 1'b0);
            start = (set_err == 8'h00);
          end
          else
            set_err = (8'h01 << pfc_pkg::SR_PERR) | (8'h01 << pfc_pkg::SR_EERR);
        end
        SQ_OTP:
        begin
          next_rmode = pfc_pkg::RM_STATUS;
          start_kind = pfc_pkg::OP_OTP;
          set_err = fail_bits(pfc_pkg::OP_OTP, vpp_ok,
            i_avs_address < pfc_pkg::OTP_BASE || i_avs_address > pfc_pkg::OTP_LAST ||
            (otp_idx >= pfc_pkg::OTP_USER_LO && !otp[pfc_pkg::OTP_LOCK_IDX][pfc_pkg::LOCK_USER_BIT]) ||
            (otp_idx != pfc_pkg::OTP_LOCK_IDX && otp_idx < pfc_pkg::OTP_USER_LO &&
             !otp[pfc_pkg::OTP_LOCK_IDX][pfc_pkg::LOCK_FACT_BIT]));
          start = (set_err == 8'h00);
          otp_we = start;
        end
        SQ_PROG:
        begin
          next_rmode = pfc_pkg::RM_STATUS;
          set_err = fail_bits(pfc_pkg::OP_WORD, vpp_ok, prot[blk_of(i_avs_address)]);
          start = (set_err == 8'h00);
        end
        SQ_ERASE:
        begin
          next_rmode = pfc_pkg::RM_STATUS;
          start_kind = pfc_pkg::OP_ERASE;
          if (cmd == pfc_pkg::CMD_CONFIRM)
          begin
            set_err = fail_bits(pfc_pkg::OP_ERASE, vpp_ok, prot[blk_of(i_avs_address)]);
            start = (set_err == 8'h00);
          end
          else
            set_err = (8'h01 << pfc_pkg::SR_PERR) | (8'h01 << pfc_pkg::SR_EERR);
        end
        SQ_BCOUNT:
          if (blk_of(i_avs_address) != blk_of(buf_base) || i_avs_writedata > pfc_pkg::BUF_MAX)
            set_err = (8'h01 << pfc_pkg::SR_PERR) | (8'h01 << pfc_pkg::SR_EERR);
          else
            next_seq = SQ_BDATA;
        SQ_BDATA:
          if (!buf_first && i_avs_address[20:pfc_pkg::ROW_LSB] != buf_row[20:pfc_pkg::ROW_LSB])
            set_err = (8'h01 << pfc_pkg::SR_PERR) | (8'h01 << pfc_pkg::SR_EERR);
          else
            next_seq = (buf_left == 4'h0) ? SQ_BCONF : SQ_BDATA;
        SQ_BCONF:
        begin
          start_kind = pfc_pkg::OP_BUF;
          start_addr = buf_row;
          if (cmd == pfc_pkg::CMD_CONFIRM)
          begin
            set_err = fail_bits(pfc_pkg::OP_BUF, 1'b1, prot[blk_of(buf_row)]);
            start = (set_err == 8'h00);
          end
          else
            set_err = (8'h01 << pfc_pkg::SR_PERR) | (8'h01 << pfc_pkg::SR_EERR);
        end
        default: next_seq = SQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
    begin
      seq <= SQ_IDLE;
      rmode <= pfc_pkg::RM_ARRAY;
    end
    else if (i_ce)
    begin
      seq <= next_seq;
      rmode <= next_rmode;
    end

  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
    begin
      buf_base <= '0;
      buf_row <= '0;
      buf_first <= 1'b0;
      buf_left <= 4'h0;
    end
    else if (i_ce && wr)
    begin
      if (buf_load)
        buf_base <= i_avs_address;
      if (seq == SQ_BCOUNT)
      begin
        buf_left <= i_avs_writedata[3:0];
        buf_first <= 1'b1;
      end
      if (seq == SQ_BDATA)
      begin
        buf_first <= 1'b0;
        buf_left <= buf_left - 4'h1;
        if (buf_first)
          buf_row <= i_avs_address;
      end
    end

  // error bits are sticky; a new error in the clearing cycle survives
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
      err <= 8'h00;
    else if (i_ce)
      err <= ((clr_err ? (err & ~pfc_pkg::SR_ERR_MASK) : err) | set_err) & pfc_pkg::SR_ERR_MASK;

  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
      o_burst_config <= 16'h0000;
    else if (i_ce && bcr_we)
      o_burst_config <= i_avs_address[15:0];

  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
    begin
      o_op_start <= 1'b0;
      o_op_kind <= pfc_pkg::OP_WORD;
      o_op_address <= '0;
      o_op_word <= 16'h0000;
    end
    else if (i_ce)
    begin
      o_op_start <= start;
      if (start)
      begin
        o_op_kind <= start_kind;
        o_op_address <= start_addr;
        o_op_word <= i_avs_writedata;
      end
    end

  // non-volatile state: only power-on or unprotect-all clears it, never the bus reset
  for (genvar g = 0; g < pfc_pkg::NUM_BLOCKS; g++)
  begin : g_prot
    always_ff @(posedge i_mclk or posedge i_por)
      if (i_por)
        prot[g] <= 1'b0;
      else if (i_ce && pec_done && o_op_kind == pfc_pkg::OP_UNPROT)
        prot[g] <= 1'b0;
      else if (i_ce && pec_done && o_op_kind == pfc_pkg::OP_PROT && blk_of(o_op_address) == 6'(g))
        prot[g] <= 1'b1;
  end

  // programming only clears bits, so only power-on brings the user lock bit back; the factory one never
  always_ff @(posedge i_mclk or posedge i_por)
    if (i_por)
    begin
      otp[0] <= pfc_pkg::LOCK_RESET;
      for (int i = 1; i < pfc_pkg::OTP_WORDS; i++)
        otp[i] <= pfc_pkg::OTP_ERASED;
    end
    else if (i_ce && otp_we)
      otp[otp_idx] <= otp[otp_idx] & i_avs_writedata;

  assign status = {~o_op_busy, susp_erase, err[5:3], susp_prog, err[1], 1'b0};

  // read data is registered in the wait cycle and held until the next read
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
      o_avs_readdata <= 16'h0000;
    else if (i_ce && i_avs_read && !ack)
      case (rmode)
        pfc_pkg::RM_STATUS: o_avs_readdata <= {8'h00, status};
        pfc_pkg::RM_QUERY: o_avs_readdata <= 16'h0000;
        pfc_pkg::RM_IDENT:
          if (i_avs_address == pfc_pkg::ID_MFR_ADDR)
            o_avs_readdata <= MFR_CODE;
          else if (i_avs_address == pfc_pkg::ID_DEV_ADDR)
            o_avs_readdata <= DEV_CODE;
          else if (i_avs_address == pfc_pkg::ID_BCR_ADDR)
            o_avs_readdata <= o_burst_config;
          else if (i_avs_address >= pfc_pkg::OTP_BASE && i_avs_address <= pfc_pkg::OTP_LAST)
            o_avs_readdata <= otp[otp_idx];
          else if (i_avs_address[pfc_pkg::BLK_LSB-1:0] == pfc_pkg::ID_PROT_OFS)
            o_avs_readdata <= {15'h0000, prot[blk_of(i_avs_address)]};
          else
            o_avs_readdata <= 16'h0000;
        default: o_avs_readdata <= i_array_word;
      endcase

  pfc_pe_ctrl #(
    .ERASE_CYC(ERASE_CYC),
    .UNPROT_CYC(UNPROT_CYC)
  ) u_pec (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_start(o_op_start),
    .i_kind(o_op_kind),
    .i_suspend(susp_req),
    .i_resume(resume_req),
    .o_busy(o_op_busy),
    .o_done(pec_done),
    .o_susp_prog(susp_prog),
    .o_susp_erase(susp_erase)
  );
endmodule // pfc_cmd_if

/* sim/pfc_cmd_if_asserts.sv */
`timescale 1ns/1ps
module pfc_cmd_if_asserts (
  // watched ports
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [20:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [15:0] i_avs_writedata,
  input wire logic [15:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_op_start,
  input wire logic [2:0] o_op_kind,
  input wire logic [20:0] o_op_address,
  input wire logic [15:0] o_op_word,
  input wire logic o_op_busy,
  input wire logic [15:0] o_burst_config
);
  logic [7:0] prev_cmd;
  logic acc_wr;
  logic acc_rd;
  assign acc_wr = i_avs_write && !o_avs_waitrequest;
  assign acc_rd = i_avs_read && !o_avs_waitrequest;
  // last accepted write code, so second cycles can be tied to their setup
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      prev_cmd <= 8'h00;
    else if (acc_wr)
      prev_cmd <= i_avs_writedata[7:0];
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_one_wait: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("wait state count");
  a_start_pulse: assert property (o_op_start |=> !o_op_start) else $error("start too long");
  a_start_busy: assert property (o_op_start |=> o_op_busy) else $error("no busy");
  a_cfg_map: assert property (prev_cmd == 8'h60 && acc_wr && i_avs_writedata[7:0] == 8'h03
    |=> o_burst_config == $past(i_avs_address[15:0])) else $error("config value");
  a_cfg_write_only: assert property ($changed(o_burst_config) |-> $past(acc_wr)) else $error("config moved");
  a_prot_start: assert property (prev_cmd == 8'h60 && acc_wr && i_avs_writedata[7:0] == 8'h01
    |=> o_op_start && o_op_kind == 3'h3 && o_op_address == $past(i_avs_address)) else $error("protect");
  a_unprot_start: assert property (prev_cmd == 8'h60 && acc_wr && i_avs_writedata[7:0] == 8'hD0
    |=> o_op_start && o_op_kind == 3'h4) else $error("unprotect");
  a_busy_status: assert property (acc_rd && o_op_busy && $past(o_op_busy) |-> !o_avs_readdata[7])
    else $error("ready while busy");
  a_word_latch: assert property ((prev_cmd == 8'h40 || prev_cmd == 8'h10) && acc_wr ##1 o_op_start
    && o_op_kind == 3'h0 |-> o_op_word == $past(i_avs_writedata) && o_op_address == $past(i_avs_address))
    else $error("word hand-off");
  a_susp_latency: assert property (acc_wr && i_avs_writedata[7:0] == 8'hB0 && o_op_busy && o_op_kind <= 3'h1
    |-> ##[1:201] !o_op_busy) else $error("suspend too slow");
  c_protect: cover property (o_op_start && o_op_kind == 3'h3);
  c_otp: cover property (o_op_start && o_op_kind == 3'h5);
  c_buffer: cover property (o_op_start && o_op_kind == 3'h1);
endmodule // pfc_cmd_if_asserts

/* sim/pfc_host.sv */
`timescale 1ns/1ps
module pfc_host (
  // bus from device
  input wire logic i_mclk,
  input wire logic i_wait,
  input wire logic [15:0] i_rdata,
  // bus to device
  output logic [20:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [15:0] o_wdata
);
  initial
  begin
    o_addr = 21'h000000;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 16'h0000;
  end
  // released lines show the inverse so stale values cannot pass for valid
  task automatic xfer(input logic w, input logic [20:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge i_mclk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= w;
    o_rd <= !w;
    do
      @(posedge i_mclk);
    while (i_wait !== 1'b0);
    q = i_rdata;
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
endmodule // pfc_host

/* sim/pfc_cmd_if_tb.sv */
`timescale 1ns/1ps
module pfc_cmd_if_tb;
  logic i_mclk;
  logic i_rst;
  logic i_por;
  logic [20:0] addr;
  logic rd_s;
  logic wr_s;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic waitreq;
  logic [15:0] cfg;
  logic [15:0] q;
  int n_mismatch = 0;
  int total_checks = 0;
  localparam logic [20:0] BLK3 = 21'h018000;
  initial
  begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  pfc_host i_host (.i_mclk(i_mclk), .i_wait(waitreq), .i_rdata(rdata), .o_addr(addr), .o_rd(rd_s),
    .o_wr(wr_s), .o_wdata(wdata));
  pfc_cmd_if #(.ERASE_CYC(50), .UNPROT_CYC(60)) i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_por(i_por),
    .i_ce(1'b1), .i_avs_address(addr), .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_vpp_ok(1'b1), .i_array_word(16'h5EED),
    .o_op_start(), .o_op_kind(), .o_op_address(), .o_op_word(), .o_op_busy(), .o_burst_config(cfg));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    i_host.xfer(1'b1, a[20:0], d, q);
  endtask
  task automatic rc(input logic [31:0] a, input logic [15:0] exp);
    i_host.xfer(1'b0, a[20:0], 16'h0000, q);
    chk(q, exp);
  endtask
  // status poll until ready, bounded; a stuck device fails the next compare
  task automatic poll(input logic [15:0] exp);
    int i = 0;
    do
    begin
      i_host.xfer(1'b0, 21'h000000, 16'h0000, q);
      i++;
    end
    while (q[7] !== 1'b1 && i < 4000);
    chk(q, exp);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge i_mclk);
    n_mismatch++;
    $display("timeout");
    report_and_stop();
  end
  initial
  begin
    i_rst = 1'b1;
    i_por = 1'b1;
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    i_por <= 1'b0;
    repeat (3) @(posedge i_mclk);
    wr(0, 16'h0090);
    rc(21'h000000, 16'h1A2B);
    rc(21'h000001, 16'h3C4D);
    rc(21'h000080, 16'hFFFE);
    wr(0, 16'h0098);
    rc(0, 16'h0000);
    $display("ident done");
    wr(0, 16'h0060);
    wr(21'h01A5A5, 16'h0003);
    // the value is launched at the taking edge; look once it has settled
    @(negedge i_mclk);
    chk(cfg, 16'hA5A5);
    rc(7, 16'h5EED);
    wr(0, 16'h0090);
    rc(5, 16'hA5A5);
    $display("config done");
    wr(0, 16'h0060);
    wr(BLK3 + 7, 16'h0001);
    rc(0, 16'h0000);
    poll(16'h0080);
    wr(0, 16'h0090);
    rc(BLK3 + 2, 16'h0001);
    rc(BLK3 + 21'h008002, 16'h0000);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_mclk);
    wr(0, 16'h0090);
    rc(BLK3 + 2, 16'h0001);
    wr(0, 16'h0060);
    wr(0, 16'h00D0);
    poll(16'h0080);
    wr(0, 16'h0090);
    rc(BLK3 + 2, 16'h0000);
    $display("protect done");
    wr(0, 16'h0060);
    wr(0, 16'h0055);
    wr(0, 16'h0070);
    rc(0, 16'h00B0);
    wr(0, 16'h0050);
    rc(0, 16'h0080);
    $display("sequence done");
    wr(0, 16'h00FF);
    wr(0, 16'h00C0);
    wr(21'h000085, 16'h1234);
    wr(0, 16'h00B0);
    poll(16'h0080);
    wr(0, 16'h0090);
    rc(21'h000085, 16'h1234);
    wr(0, 16'h00FF);
    wr(0, 16'h00C0);
    wr(21'h000080, 16'hFFFD);
    poll(16'h0080);
    wr(0, 16'h00FF);
    wr(0, 16'h00C0);
    wr(21'h000086, 16'h5678);
    poll(16'h0092);
    wr(0, 16'h0050);
    wr(0, 16'h0090);
    rc(21'h000086, 16'hFFFF);
    rc(21'h000080, 16'hFFFC);
    $display("otp done");
    wr(0, 16'h0040);
    wr(BLK3 + 9, 16'h2222);
    poll(16'h0080);
    wr(0, 16'h0010);
    wr(BLK3 + 8, 16'h3333);
    poll(16'h0080);
    wr(0, 16'h0020);
    wr(BLK3, 16'h00D0);
    poll(16'h0080);
    wr(BLK3, 16'h00E8);
    wr(BLK3, 16'h0000);
    wr(BLK3 + 1, 16'h1111);
    wr(BLK3, 16'h00D0);
    wr(0, 16'h00B0);
    poll(16'h0084);
    wr(0, 16'h00D0);
    poll(16'h0080);
    $display("program done");
    report_and_stop();
  end
endmodule // pfc_cmd_if_tb
bind pfc_cmd_if pfc_cmd_if_asserts i_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_op_start(o_op_start),
  .o_op_kind(o_op_kind), .o_op_address(o_op_address), .o_op_word(o_op_word), .o_op_busy(o_op_busy),
  .o_burst_config(o_burst_config));
